// ===== verilog/crc_gen_pkg.sv
// Constants, types and helpers shared by the checksum generator files
package crc_gen_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [15:0] CTRL_OFF = 16'h3030;
    localparam logic [15:0] VALUE_OFF = 16'h3040;
    localparam logic [15:0] TAPS_OFF = 16'h3050;
    localparam logic [3:0] ALIAS_WRITE = 4'h0;
    localparam logic [3:0] ALIAS_CLR = 4'h4;
    localparam logic [3:0] ALIAS_SET = 4'h8;
    localparam logic [3:0] ALIAS_INV = 4'hC;
    localparam int unsigned ALIAS_LSB = 4;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int unsigned MODE_BIT = 15;
    localparam int unsigned POLYNOMIAL_LENGTH_LSB = 8;
    localparam int unsigned POLYNOMIAL_LENGTH_W = 5;
    localparam int unsigned EN_BIT = 7;
    localparam int unsigned APPEND_BIT = 6;
    localparam int unsigned CHAN_LSB = 0;
    localparam int unsigned CHAN_W = 3;
    localparam logic [31:0] CTRL_IMPL_MASK = 32'h0000_9FC7;

    // ****************************************
    // Reset values and widths
    // ****************************************
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] VALUE_RST = 32'h0000_0000;
    localparam logic [31:0] TAPS_RST = 32'h0000_0000;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IP_HALF_W = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {REG_NONE, REG_CTRL, REG_VALUE, REG_TAPS} reg_sel_e;
    typedef enum logic [1:0] {OP_WRITE, OP_CLR, OP_SET, OP_INV} reg_op_e;

    // Bits at and below the polynomial length
    function automatic logic [31:0] len_mask(input logic [POLYNOMIAL_LENGTH_W-1:0] polynomial_length);
        return 32'hFFFF_FFFF >> (5'h1F - polynomial_length);
    endfunction

    function automatic logic [31:0] byte_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // Plain write or clear/set/invert alias applied under byte strobes
    function automatic logic [31:0] apply_op(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb, input reg_op_e op);
        logic [31:0] m;
        m = wd & byte_mask(strb);
        unique case (op)
            OP_WRITE: return (old & ~byte_mask(strb)) | m;
            OP_CLR: return old & ~m;
            OP_SET: return old | m;
            OP_INV: return old ^ m;
        endcase
    endfunction

endpackage

// ===== verilog/crc_lfsr_step.sv
// One data word shifted through the tapped shift register, least significant bit first
`timescale 1ns/10ps
`default_nettype none
module crc_lfsr_step import crc_gen_pkg::*; #(
    parameter int unsigned W = 32
) (
    // Present state and configuration
    input wire logic [W-1:0] seed,
    input wire logic [W-1:0] taps,
    input wire logic [POLYNOMIAL_LENGTH_W-1:0] polynomial_length,
    // Word to absorb
    input wire logic [W-1:0] data,
    output logic [W-1:0] result
);

    initial begin
        if (W != (1 << POLYNOMIAL_LENGTH_W)) $error("crc_lfsr_step: W must match the length field");
    end

    always_comb begin
        logic [W-1:0] s;
        logic [W-1:0] t;
        logic fb;
        s = seed & len_mask(polynomial_length);
        t = '0;
        fb = 1'b0;
        for (int b = 0; b < W; b++) begin
            fb = s[polynomial_length] ^ data[b];
            t[0] = taps[0] & fb;
            for (int i = 1; i < W; i++) begin
                t[i] = s[i-1] ^ (taps[i] & fb);
            end
            s = t & len_mask(polynomial_length);
        end
        result = s;
    end

endmodule // crc_lfsr_step
`default_nettype wire

// ===== verilog/ip_sum_step.sv
// Ones'-complement addition of both halves of a word into a 16-bit sum
`timescale 1ns/10ps
`default_nettype none
module ip_sum_step import crc_gen_pkg::*; (
    // Running sum and word to absorb
    input wire logic [IP_HALF_W-1:0] sum,
    input wire logic [DATA_W-1:0] data,
    output logic [IP_HALF_W-1:0] result
);

    always_comb begin
        logic [IP_HALF_W:0] a;
        logic [IP_HALF_W:0] b;
        a = {1'b0, sum} + {1'b0, data[IP_HALF_W-1:0]};
        a = {1'b0, a[IP_HALF_W-1:0]} + {{IP_HALF_W{1'b0}}, a[IP_HALF_W]};
        b = {1'b0, a[IP_HALF_W-1:0]} + {1'b0, data[DATA_W-1:IP_HALF_W]};
        b = {1'b0, b[IP_HALF_W-1:0]} + {{IP_HALF_W{1'b0}}, b[IP_HALF_W]};
        result = b[IP_HALF_W-1:0];
    end

endmodule // ip_sum_step
`default_nettype wire

// ===== verilog/crc_generator.sv
// Checksum generator with AXI4-Lite register access
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Writing the value register seeds the generator with the written word.
// - Reading the value register returns the running checksum and changes nothing.
// - In shift-register mode value bits above the length read as zero.
// - Control bit 15 picks IP header checksum (one) or shift-register mode (zero).
// - In IP header mode the upper 16 value bits read as zero.
// - In IP header mode writes are converted; reads give ones'-complement checksum.
// - In IP header mode the tap register does not affect the checksum.
// - A one tap bit puts feedback XOR at that stage's input.
// - A zero tap bit makes that stage copy the preceding stage directly; stage 0 loads zero instead.
// - Aliases at +0x4, +0x8, +0xC clear, set or invert written one bits.
// - Unimplemented bits ignore writes and read zero; implemented bits reset to zero.
module crc_generator import crc_gen_pkg::*; #(
    parameter int unsigned ADDR_W = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // Write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address channel
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // Read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Data words from the DMA channels
    input wire logic feed_valid,
    input wire logic [CHAN_W-1:0] feed_channel,
    input wire logic [31:0] feed_data
);

    initial begin
        if (ADDR_W < 16) $error("crc_generator: ADDR_W must be at least 16");
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] value;
        logic [31:0] taps;
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_s;

    localparam state_s RST_STATE = '{ctrl: CTRL_RST, value: VALUE_RST, taps: TAPS_RST, default: '0};

    state_s s_r;
    state_s s_nxt;

    // ****************************************
    // Decoding
    // ****************************************
    function automatic reg_sel_e decode_reg(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] base;
        base = {a[ADDR_W-1:ALIAS_LSB], {ALIAS_LSB{1'b0}}};
        if (base == ADDR_W'(CTRL_OFF)) begin
            return REG_CTRL;
        end else if (base == ADDR_W'(VALUE_OFF)) begin
            return REG_VALUE;
        end else if (base == ADDR_W'(TAPS_OFF)) begin
            return REG_TAPS;
        end
        return REG_NONE;
    endfunction

    function automatic reg_op_e decode_op(input logic [ADDR_W-1:0] a);
        logic [3:0] low;
        low = {a[ALIAS_LSB-1:2], 2'h0};
        if (low == ALIAS_CLR) begin
            return OP_CLR;
        end else if (low == ALIAS_SET) begin
            return OP_SET;
        end else if (low == ALIAS_INV) begin
            return OP_INV;
        end
        return OP_WRITE;
    endfunction

    // Software view of the running checksum
    function automatic logic [31:0] value_view(input logic [31:0] v, input logic [31:0] c);
        if (c[MODE_BIT]) begin
            return {{IP_HALF_W{1'b0}}, ~v[IP_HALF_W-1:0]};
        end
        return v & len_mask(c[POLYNOMIAL_LENGTH_LSB +: POLYNOMIAL_LENGTH_W]);
    endfunction

    // Software word turned into internal state
    function automatic logic [31:0] value_store(input logic [31:0] w, input logic [31:0] c);
        if (c[MODE_BIT]) begin
            return {{IP_HALF_W{1'b0}}, ~w[IP_HALF_W-1:0]};
        end
        return w & len_mask(c[POLYNOMIAL_LENGTH_LSB +: POLYNOMIAL_LENGTH_W]);
    endfunction

    // ****************************************
    // Checksum engines
    // ****************************************
    logic [31:0] lfsr_next;
    logic [IP_HALF_W-1:0] ip_next;
    logic feed_fire;
    logic wr_fire;
    logic ar_fire;
    reg_sel_e wr_sel;
    reg_op_e wr_op;
    reg_sel_e rd_sel;

    crc_lfsr_step #(
        .W(DATA_W)
    ) u_lfsr (
        .seed(s_r.value),
        .taps(s_r.taps),
        .polynomial_length(s_r.ctrl[POLYNOMIAL_LENGTH_LSB +: POLYNOMIAL_LENGTH_W]),
        .data(feed_data),
        .result(lfsr_next)
    );

    ip_sum_step u_ip (
        .sum(s_r.value[IP_HALF_W-1:0]),
        .data(feed_data),
        .result(ip_next)
    );

    assign feed_fire = feed_valid && s_r.ctrl[EN_BIT]
        && (feed_channel == s_r.ctrl[CHAN_LSB +: CHAN_W]);
    assign wr_fire = s_r.aw_have && s_r.w_have && !s_r.bvalid;
    assign ar_fire = s_r.arready && arvalid;
    assign wr_sel = decode_reg(s_r.aw_addr);
    assign wr_op = decode_op(s_r.aw_addr);
    assign rd_sel = decode_reg(araddr);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [31:0] fed;
        s_nxt = s_r;
        fed = s_r.value;
        // Absorb a word; mode picks the engine, taps unused for IP sums
        if (feed_fire) begin
            if (s_r.ctrl[MODE_BIT]) begin
                fed = {{IP_HALF_W{1'b0}}, ip_next};
            end else begin
                fed = lfsr_next;
            end
        end
        s_nxt.value = fed;
        // Write address and data are taken in either order
        if (s_r.awready && awvalid) begin
            s_nxt.aw_addr = awaddr;
            s_nxt.aw_have = 1'b1;
        end
        if (s_r.wready && wvalid) begin
            s_nxt.w_data = wdata;
            s_nxt.w_strb = wstrb;
            s_nxt.w_have = 1'b1;
        end
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        // Register update once both halves are held
        if (wr_fire) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            unique case (wr_sel)
                REG_CTRL: begin
                    s_nxt.ctrl = apply_op(s_r.ctrl, s_r.w_data, s_r.w_strb, wr_op) & CTRL_IMPL_MASK;
                end
                REG_VALUE: begin
                    s_nxt.value = value_store(apply_op(value_view(fed, s_r.ctrl), s_r.w_data,
                                              s_r.w_strb, wr_op), s_r.ctrl);
                end
                REG_TAPS: begin
                    s_nxt.taps = apply_op(s_r.taps, s_r.w_data, s_r.w_strb, wr_op);
                end
                REG_NONE: begin
                    s_nxt.bresp = RESP_DECERR;
                end
            endcase
        end
        s_nxt.awready = !s_nxt.aw_have;
        s_nxt.wready = !s_nxt.w_have;
        // Reads only sample state
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (ar_fire) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            unique case (rd_sel)
                REG_CTRL: s_nxt.rdata = s_r.ctrl & CTRL_IMPL_MASK;
                REG_VALUE: s_nxt.rdata = value_view(s_r.value, s_r.ctrl);
                REG_TAPS: s_nxt.rdata = s_r.taps;
                REG_NONE: begin
                    s_nxt.rdata = '0;
                    s_nxt.rresp = RESP_DECERR;
                end
            endcase
        end
        s_nxt.arready = !s_nxt.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= RST_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign awready = s_r.awready;
    assign wready = s_r.wready;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign arready = s_r.arready;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rresp;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic full_strb;
    assign full_strb = (s_r.w_strb == 4'hF);

    AST_VALUE_SEED: assert property (
        wr_fire && wr_sel == REG_VALUE && wr_op == OP_WRITE && full_strb && !feed_fire
        && !s_r.ctrl[MODE_BIT]
        |=> s_r.value == ($past(s_r.w_data) & len_mask($past(s_r.ctrl[POLYNOMIAL_LENGTH_LSB +: POLYNOMIAL_LENGTH_W]))))
        else $error("value write did not seed the generator");

    AST_READ_NO_SIDE: assert property (
        ar_fire && !wr_fire && !feed_fire |=> $stable(s_r.value) && $stable(s_r.ctrl))
        else $error("read disturbed generator state");

    AST_LFSR_HIGH_ZERO: assert property (
        ar_fire && rd_sel == REG_VALUE && !s_r.ctrl[MODE_BIT]
        |=> (rdata & ~len_mask($past(s_r.ctrl[POLYNOMIAL_LENGTH_LSB +: POLYNOMIAL_LENGTH_W]))) == '0)
        else $error("bits above polynomial length read nonzero");

    AST_IP_HIGH_ZERO: assert property (
        ar_fire && rd_sel == REG_VALUE && s_r.ctrl[MODE_BIT]
        |=> rdata[31:IP_HALF_W] == '0 && rvalid)
        else $error("upper half nonzero in IP header mode");

    AST_IP_CONVERT: assert property (
        wr_fire && wr_sel == REG_VALUE && wr_op == OP_WRITE && full_strb && !feed_fire
        && s_r.ctrl[MODE_BIT]
        |=> ~s_r.value[IP_HALF_W-1:0] == $past(s_r.w_data[IP_HALF_W-1:0]))
        else $error("IP header seed not held in complement form");

    AST_TAP_ZERO_SHIFT: assert property (
        feed_fire && !wr_fire && !s_r.ctrl[MODE_BIT] && s_r.taps == '0 |=> s_r.value == '0)
        else $error("untapped stages did not shift plainly");

    AST_CLR_ALIAS: assert property (
        wr_fire && wr_sel == REG_CTRL && wr_op == OP_CLR && full_strb
        |=> s_r.ctrl == ($past(s_r.ctrl) & ~$past(s_r.w_data)))
        else $error("clear alias misbehaved");

    AST_CTRL_UNIMPL: assert property (
        (s_r.ctrl & ~CTRL_IMPL_MASK) == '0)
        else $error("unimplemented control bit set");

    AST_RESET_CLEAR: assert property (
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> s_r.ctrl == '0 && s_r.value == '0 && s_r.taps == '0 && !bvalid && !rvalid)
        else $error("registers not cleared by reset");

    AST_BRESP_NEXT: assert property (
        wr_fire |=> bvalid)
        else $error("write response missing");

    AST_BRESP_HOLD: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before taken");

    AST_RDATA_HOLD: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data changed before taken");

    AST_LFSR_FEED: assert property (
        feed_fire && !wr_fire && !s_r.ctrl[MODE_BIT] |=> s_r.value == $past(lfsr_next))
        else $error("shift-register step not applied");

    AST_IP_FEED: assert property (
        feed_fire && !wr_fire && s_r.ctrl[MODE_BIT]
        |=> s_r.value == {{IP_HALF_W{1'b0}}, $past(ip_next)})
        else $error("IP header sum not applied");

    AST_FEED_IDLE: assert property (
        !feed_fire && !wr_fire |=> $stable(s_r.value))
        else $error("checksum changed without a fed word");

    COV_IP_FEED: cover property (feed_fire && s_r.ctrl[MODE_BIT]);
    COV_LFSR_FEED: cover property (feed_fire && !s_r.ctrl[MODE_BIT] && s_r.taps != '0);
    COV_INV_VALUE: cover property (wr_fire && wr_sel == REG_VALUE && wr_op == OP_INV);
    COV_WRITE_WITH_FEED: cover property (wr_fire && wr_sel == REG_VALUE && feed_fire);
    COV_ZERO_TAP_FEED: cover property (feed_fire && !s_r.ctrl[MODE_BIT] && s_r.taps == '0);

endmodule // crc_generator
`default_nettype wire

// ===== verif/test_crc_generator.sv
// Self-checking testbench for the checksum generator register block
`timescale 1ns/10ps
`default_nettype none
module test_crc_generator import crc_gen_pkg::*;;
    // ****************************************
    // Clock, reset and design ports
    // ****************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, feed_data = '0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic feed_valid = 1'b0;
    logic [CHAN_W-1:0] feed_channel = '0;
    int err_total = 0;
    int comparisons = 0;
    logic [33:0] bq[$];
    logic [33:0] rq[$];
    logic [31:0] rnd_state = 32'h0000CC84;
    always #10 aclk = ~aclk;

    crc_generator DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .feed_valid(feed_valid), .feed_channel(feed_channel),
        .feed_data(feed_data));

    // ****************************************
    // Reporting and reference models
    // ****************************************
    task automatic close_out;
        $display("Comparisons: %0d, mismatches: %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: resp/data %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] rnd();
        rnd_state = {rnd_state[30:0], rnd_state[31] ^ rnd_state[21] ^ rnd_state[1] ^ rnd_state[0]};
        return rnd_state;
    endfunction

    // Tapped shift register, data least significant bit first
    function automatic logic [31:0] shift_ref(input logic [31:0] s, input logic [31:0] t,
                                              input logic [31:0] d, input int pl);
        logic [31:0] r;
        logic fb;
        r = s;
        for (int b = 0; b < 32; b++) begin
            fb = r[pl] ^ d[b];
            for (int i = pl; i > 0; i--) begin
                r[i] = r[i-1] ^ (t[i] & fb);
            end
            r[0] = t[0] & fb;
        end
        for (int i = pl + 1; i < 32; i++) begin
            r[i] = 1'b0;
        end
        return r;
    endfunction

    function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0, s[16]};
    endfunction

    // ****************************************
    // Bus master and result watcher
    // ****************************************
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] resp);
        bit aw_p, w_p, b_p;
        int n;
        aw_p = 1;
        w_p = 1;
        b_p = 1;
        n = 0;
        bq.push_back({resp, 32'h0});
        awaddr <= a;
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while ((aw_p || w_p || b_p) && n < 200) begin
            @(posedge aclk);
            n++;
            if (aw_p && awready === 1'b1) begin aw_p = 0; awvalid <= 1'b0; end
            if (w_p && wready === 1'b1) begin w_p = 0; wvalid <= 1'b0; end
            if (b_p && bvalid === 1'b1) begin b_p = 0; bready <= 1'b0; end
        end
        if (aw_p || w_p || b_p) begin
            err_total++;
            close_out();
        end
        // Let an edge pass so the next call does not re-raise bready in this step
        @(posedge aclk);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] resp);
        bit ar_p, r_p;
        int n;
        ar_p = 1;
        r_p = 1;
        n = 0;
        rq.push_back({resp, exp});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while ((ar_p || r_p) && n < 200) begin
            @(posedge aclk);
            n++;
            if (ar_p && arready === 1'b1) begin ar_p = 0; arvalid <= 1'b0; end
            if (r_p && rvalid === 1'b1) begin r_p = 0; rready <= 1'b0; end
        end
        if (ar_p || r_p) begin
            err_total++;
            close_out();
        end
        // Let an edge pass so the next call does not re-raise rready in this step
        @(posedge aclk);
    endtask

    task automatic feed(input logic [CHAN_W-1:0] ch, input logic [31:0] d);
        feed_channel <= ch;
        feed_data <= d;
        feed_valid <= 1'b1;
        @(posedge aclk);
        feed_valid <= 1'b0;
    endtask

    always @(posedge aclk) begin
        if (bvalid === 1'b1 && bready === 1'b1) begin
            check({bresp, 32'h0}, (bq.size() > 0) ? bq.pop_front() : 34'h3_FFFF_FFFF);
        end
        if (rvalid === 1'b1 && rready === 1'b1) begin
            check({rresp, rdata}, (rq.size() > 0) ? rq.pop_front() : 34'h3_FFFF_FFFF);
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        logic [31:0] s, t, d, ctl, expv;
        logic [15:0] sum;
        logic [CHAN_W-1:0] ch;
        int pl;
        int pls[3] = '{31, 7, 16};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CTRL_OFF, CTRL_RST, RESP_OKAY);
        rd(VALUE_OFF, VALUE_RST, RESP_OKAY);
        rd(TAPS_OFF, TAPS_RST, RESP_OKAY);
        wr(CTRL_OFF, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        rd(CTRL_OFF, CTRL_IMPL_MASK, RESP_OKAY);
        wr(CTRL_OFF + 16'(ALIAS_CLR), 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        rd(CTRL_OFF, 32'h0, RESP_OKAY);
        wr(CTRL_OFF + 16'(ALIAS_SET), 32'h0000_8040, 4'hF, RESP_OKAY);
        rd(CTRL_OFF + 16'(ALIAS_CLR), 32'h0000_8040, RESP_OKAY);
        wr(CTRL_OFF + 16'(ALIAS_INV), 32'h0000_8000, 4'hF, RESP_OKAY);
        rd(CTRL_OFF, 32'h0000_0040, RESP_OKAY);
        t = rnd();
        wr(TAPS_OFF, t, 4'hF, RESP_OKAY);
        wr(TAPS_OFF + 16'(ALIAS_INV), 32'hFFFF_FFFF, 4'h3, RESP_OKAY);
        t = t ^ 32'h0000_FFFF;
        rd(TAPS_OFF, t, RESP_OKAY);
        // Shift-register mode at several lengths with random taps
        foreach (pls[k]) begin
            pl = pls[k];
            d = rnd();
            ch = d[CHAN_W-1:0];
            ctl = (32'(pl) << POLYNOMIAL_LENGTH_LSB) | (32'h1 << EN_BIT) | 32'(ch);
            wr(CTRL_OFF, ctl, 4'hF, RESP_OKAY);
            t = rnd();
            wr(TAPS_OFF, t, 4'hF, RESP_OKAY);
            s = rnd();
            wr(VALUE_OFF, s, 4'hF, RESP_OKAY);
            expv = s & (32'hFFFF_FFFF >> (31 - pl));
            rd(VALUE_OFF, expv, RESP_OKAY);
            rd(VALUE_OFF, expv, RESP_OKAY);
            d = rnd();
            feed(ch, d);
            expv = shift_ref(expv, t, d, pl);
            rd(VALUE_OFF, expv, RESP_OKAY);
            feed(ch ^ 3'h1, rnd());
            rd(VALUE_OFF, expv, RESP_OKAY);
        end
        wr(CTRL_OFF + 16'(ALIAS_CLR), 32'h1 << EN_BIT, 4'hF, RESP_OKAY);
        feed(ch, rnd());
        rd(VALUE_OFF, expv, RESP_OKAY);
        // Zero taps: stage 0 loads zero and the others copy their neighbour, so a whole word flushes the register
        wr(CTRL_OFF + 16'(ALIAS_SET), 32'h1 << EN_BIT, 4'hF, RESP_OKAY);
        wr(TAPS_OFF, 32'h0, 4'hF, RESP_OKAY);
        feed(ch, rnd());
        rd(VALUE_OFF, 32'h0, RESP_OKAY);
        // IP header mode
        ch = 3'h5;
        wr(CTRL_OFF, (32'h1 << MODE_BIT) | (32'h1 << EN_BIT) | 32'(ch), 4'hF, RESP_OKAY);
        s = rnd() | 32'hFFFF_0000;
        wr(VALUE_OFF, s, 4'hF, RESP_OKAY);
        rd(VALUE_OFF, {16'h0, s[15:0]}, RESP_OKAY);
        sum = ~s[15:0];
        for (int j = 0; j < 2; j++) begin
            wr(TAPS_OFF, rnd(), 4'hF, RESP_OKAY);
            d = rnd();
            feed(ch, d);
            sum = oc_add(oc_add(sum, d[15:0]), d[31:16]);
            rd(VALUE_OFF, {16'h0, ~sum}, RESP_OKAY);
        end
        // Unmapped places
        wr(16'h3060, 32'hFFFF_FFFF, 4'hF, RESP_DECERR);
        rd(16'h3060, 32'h0, RESP_DECERR);
        rd(16'hB030, 32'h0, RESP_DECERR);
        repeat (2) @(posedge aclk);
        close_out();
    end
endmodule // test_crc_generator
`default_nettype wire
